//--- rtl/lbt_top.sv
// Loopback selection, PRBS generator and checker, packet counters and PMA test modes
// What this block does
// - Writing update bit 1 snapshots the error byte count for the next read.
// - Status bit 8 reads one while the PRBS checker is locked.
// - Digital loopback returns MAC transmit data to MAC receive before analog front end.
// - Digital loopback isolates the receive analog circuitry.
// - Analog loopback delivers echoes decoded from the line to the MAC.
// - Reverse loopback sends line receive data back out to the link partner.
// - Reverse loopback isolates the MAC transmit path.
// - MAC-side generation uses generator 0x55BF and checker control 0x1555.
// - Cable-side checking uses checker control 0x0557, the internal PRBS path.
// - Reverse loopback MAC checker code depends on the active MAC interface.
// - Outside near and reverse loopbacks, generator data goes both to the line and toward the MAC.
// - Clock routing value 0x000D puts the test clock on the clock pin in follower mode.
// - Test mode comes from bits 15 to 13 of the test control register.
// - Mode 1 sends +1 for at least 600 ns then -1, repeating.
// - Mode 2 sends alternating +1 and -1 symbols each clock.
// - Mode 4 runs scrambler 1+x^9+x^11; low bit s0, high bit s1 xor s4.
// - Mode 4 maps 00 to 0, 01 to +1, 10 to 0, 11 to -1.
// - Mode 5 sends pseudo-random three-level symbols.
// - Loopback code 0x0102 loops before the PMA and isolates receive PMA.
`timescale 1ns/1ps
`include "lbt_map.svh"
module lbt_top (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire lbt_pkg::lbt_mgmt_req_t mgmt_req,
	output logic [15:0]            mgmt_rdata,
	output logic                   mgmt_rvalid,
	input  wire lbt_pkg::lbt_macif_t    mac_if,
	input  wire logic              follower_mode,
	input  wire lbt_pkg::lbt_mii_t      mac_tx,
	output logic                   mac_tx_ready,
	output lbt_pkg::lbt_byte_t     mac_rx,
	input  wire lbt_pkg::lbt_byte_t     line_rx,
	output logic                   line_tx_valid,
	output logic [7:0]             line_tx_data,
	input  wire logic              line_tx_ready,
	output logic [1:0]             tm_symbol,
	output logic                   tm_active,
	output logic                   rx_analog_isolate,
	output logic                   rx_pma_isolate,
	output logic                   mac_tx_isolate,
	output logic                   clock_output_pin
);
	import lbt_pkg::*;

	// ==================================================
	// State
	typedef struct packed {
		logic [15:0] lb_sel;
		logic [15:0] chk_ctrl;
		logic [15:0] gen_cfg;
		logic [15:0] clk_route;
		logic [15:0] tm_ctrl;
		logic [14:0] hist;
		logic [7:0]  err_cnt;
		logic [7:0]  err_snap;
		logic [1:0]  good_cnt;
		logic [1:0]  bad_cnt;
		lbt_chk_st_t chk_st;
		logic [14:0] gen_lfsr;
		logic [10:0] scr;
		logic [6:0]  tm_cnt;
		logic        tm_pol;
		logic        tclk;
		logic [31:0] pkt_cnt;
		logic [15:0] err_pkt;
		logic [15:0] pkt_hi_snap;
		logic [15:0] err_pkt_snap;
		logic        in_frame;
		logic        frame_err;
		logic [15:0] rdata;
		logic        rvalid;
		lbt_byte_t   mac_rx;
		logic [1:0]  sym;
		logic        rx_iso;
		logic        pma_iso;
		logic        tx_iso;
		logic        clk_pin;
	} lbt_state_t;

	lbt_state_t  st_q;
	lbt_state_t  st_d;

	logic        lb_pcs;
	logic        lb_dig;
	logic        lb_ana;
	logic        lb_rev;
	logic        lb_near;
	logic        gen_on;
	logic        cable_chk;
	logic        mac_chk;
	logic [15:0] mac_chk_code;
	logic [2:0]  tm_mode;
	logic [22:0] gen_next;
	logic [15:0] chk_next;
	logic        scr_bit;
	logic [1:0]  tm4_pair;

	logic        fifo_in_valid;
	logic        fifo_in_ready;
	logic [7:0]  fifo_in_data;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	logic [7:0]  fifo_out_data;
	lbt_byte_t   rx_stream;

	// ==================================================
	// Byte-wide PRBS x^15+x^14+1: returns {state, byte}, bits produced MSB first
	function automatic logic [22:0] prbs_byte(input logic [14:0] s);
		logic [14:0] t;
		logic [7:0]  b;
		t = s;
		b = '0;
		for (int i = 7; i >= 0; i--) begin
			b[i] = t[14] ^ t[13];
			t = {t[13:0], b[i]};
		end
		return {t, b};
	endfunction

	// Self-synchronising check: predicts each bit from the last 15 received bits
	function automatic logic [15:0] prbs_check(input logic [14:0] h, input logic [7:0] d);
		logic [14:0] t;
		logic        e;
		t = h;
		e = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			e = e | ((t[14] ^ t[13]) != d[i]);
			t = {t[13:0], d[i]};
		end
		return {t, e};
	endfunction

	// ==================================================
	// Loopback decode: exact codes only, so at most one path is ever active
	// one path at most
	assign lb_pcs  = (st_q.lb_sel == `LBT_LB_PCS);
	assign lb_dig  = (st_q.lb_sel == `LBT_LB_DIG);
	assign lb_ana  = (st_q.lb_sel == `LBT_LB_ANA);
	assign lb_rev  = (st_q.lb_sel == `LBT_LB_REV);
	assign lb_near = lb_pcs || lb_dig;

	assign gen_on  = (st_q.gen_cfg == `LBT_GEN_RUN);
	assign cable_chk = (st_q.chk_ctrl == `LBT_CHK_CABLE);

	// reverse loopback checker code follows the MAC interface
	always_comb begin
		case (mac_if)
			LBT_IF_RGMII: mac_chk_code = `LBT_CHK_REV_RGMII;
			LBT_IF_SGMII: mac_chk_code = `LBT_CHK_REV_SGMII;
			LBT_IF_RMII:  mac_chk_code = `LBT_CHK_REV_RMII;
			default:      mac_chk_code = `LBT_CHK_REV_MII;
		endcase
	end
	assign mac_chk = lb_rev ? (st_q.chk_ctrl == mac_chk_code) : (st_q.chk_ctrl == `LBT_CHK_MAC_LOOP);

	assign tm_mode = st_q.tm_ctrl[`LBT_TM_HI:`LBT_TM_LO];
	// unknown codes count as normal operation
	assign tm_active = (tm_mode == `LBT_TM_DROOP) || (tm_mode == `LBT_TM_JITTER) ||
		(tm_mode == `LBT_TM_DIST) || (tm_mode == `LBT_TM_PSD);

	// ==================================================
	// Transmit path into the FIFO; line receive cannot be stalled, so a full
	// FIFO in reverse loopback drops bytes rather than corrupting the line
	always_comb begin
		if (lb_rev) begin
			// line data back to the partner
			fifo_in_valid = line_rx.valid;
			fifo_in_data  = line_rx.data;
		end else if (gen_on) begin
			fifo_in_valid = 1'b1;
			fifo_in_data  = gen_next[7:0];
		end else begin
			fifo_in_valid = mac_tx.en;
			fifo_in_data  = mac_tx.data;
		end
	end

	// MAC transmit refused during reverse loopback
	assign mac_tx_ready = fifo_in_ready && !lb_rev && !gen_on;

	// Near loopbacks drain locally; test symbols stall the data path
	// loop before the analog front end
	assign fifo_out_ready = lb_near ? 1'b1 : (line_tx_ready && !tm_active);
	assign line_tx_valid  = fifo_out_valid && !lb_near && !tm_active;
	assign line_tx_data   = fifo_out_data;

	// Receive stream: looped data in near loopbacks, otherwise the hybrid output
	// echo from the line reaches the MAC
	always_comb begin
		if (lb_near) begin
			rx_stream.valid = fifo_out_valid;
			rx_stream.data  = fifo_out_data;
		end else begin
			rx_stream = line_rx;
		end
	end

	assign gen_next = prbs_byte(st_q.gen_lfsr);
	assign chk_next = prbs_check(st_q.hist, rx_stream.data);
	// scrambler 1 + x^9 + x^11
	assign scr_bit  = st_q.scr[10] ^ st_q.scr[8];
	assign tm4_pair = {st_q.scr[1] ^ st_q.scr[4], st_q.scr[0]};

	lbt_fifo #(
		.W (8),
		.D (8)
	) u_tx_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ==================================================
	// Next-state logic
	always_comb begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		st_d.tclk = ~st_q.tclk;

		// Register writes
		if (mgmt_req.wr) begin
			if (mgmt_req.addr == `LBT_REG_LB_SEL) begin
				st_d.lb_sel = mgmt_req.wdata;
			end else if (mgmt_req.addr == `LBT_REG_CHK_CTRL) begin
				st_d.chk_ctrl = mgmt_req.wdata;
			end else if (mgmt_req.addr == `LBT_REG_GEN_CFG) begin
				st_d.gen_cfg = mgmt_req.wdata;
			end else if (mgmt_req.addr == `LBT_REG_CLK_ROUTE) begin
				st_d.clk_route = mgmt_req.wdata;
			end else if (mgmt_req.addr == `LBT_REG_TM_CTRL) begin
				st_d.tm_ctrl = mgmt_req.wdata;
			end
		end

		// Generator advances only when the FIFO takes its byte
		if (gen_on && !lb_rev && fifo_in_ready) begin
			st_d.gen_lfsr = gen_next[22:8];
		end

		// PRBS checker on the receive stream
		if (cable_chk && rx_stream.valid) begin
			st_d.hist = chk_next[15:1];
			case (st_q.chk_st)
				LBT_CHK_HUNT: begin
					st_d.good_cnt = chk_next[0] ? '0 : st_q.good_cnt + 1'b1;
					if (!chk_next[0] && st_q.good_cnt == `LBT_LOCK_GOOD) begin
						st_d.chk_st = LBT_CHK_LOCK;
						st_d.bad_cnt = '0;
					end
				end
				LBT_CHK_LOCK: begin
					st_d.bad_cnt = chk_next[0] ? st_q.bad_cnt + 1'b1 : '0;
					if (chk_next[0] && st_q.err_cnt != 8'hFF) begin
						st_d.err_cnt = st_q.err_cnt + 1'b1;
					end
					if (chk_next[0] && st_q.bad_cnt == `LBT_LOCK_BAD) begin
						st_d.chk_st = LBT_CHK_HUNT;
						st_d.good_cnt = '0;
					end
				end
				default: begin
					st_d.chk_st = LBT_CHK_HUNT;
				end
			endcase
		end else if (!cable_chk) begin
			st_d.chk_st = LBT_CHK_HUNT;
			st_d.good_cnt = '0;
		end

		// update snapshots the count; a byte error that lands now is kept
		if (mgmt_req.wr && mgmt_req.addr == `LBT_REG_CHK_STAT && mgmt_req.wdata[`LBT_STAT_UPD_BIT]) begin
			st_d.err_snap = st_q.err_cnt;
			st_d.err_cnt = (st_d.err_cnt != st_q.err_cnt) ? 8'h01 : 8'h00;
		end

		// MAC-side packet counting on frame end
		if (mac_chk) begin
			st_d.in_frame = mac_tx.en;
			if (mac_tx.en) begin
				st_d.frame_err = st_q.frame_err | mac_tx.er;
			end else if (st_q.in_frame) begin
				st_d.pkt_cnt = st_q.pkt_cnt + 32'h0000_0001;
				st_d.err_pkt = st_q.err_pkt + {15'h0000, st_q.frame_err};
				st_d.frame_err = 1'b0;
			end
		end

		// Register reads; the low packet word freezes the rest of the group
		if (mgmt_req.rd) begin
			st_d.rvalid = 1'b1;
			if (mgmt_req.addr == `LBT_REG_LB_SEL) begin
				st_d.rdata = st_q.lb_sel;
			end else if (mgmt_req.addr == `LBT_REG_CHK_CTRL) begin
				st_d.rdata = st_q.chk_ctrl;
			end else if (mgmt_req.addr == `LBT_REG_GEN_CFG) begin
				st_d.rdata = st_q.gen_cfg;
			end else if (mgmt_req.addr == `LBT_REG_CLK_ROUTE) begin
				st_d.rdata = st_q.clk_route;
			end else if (mgmt_req.addr == `LBT_REG_TM_CTRL) begin
				st_d.rdata = st_q.tm_ctrl;
			end else if (mgmt_req.addr == `LBT_REG_CHK_STAT) begin
				st_d.rdata = {7'h00, (st_q.chk_st == LBT_CHK_LOCK), st_q.err_snap};
			end else if (mgmt_req.addr == `LBT_REG_PKT_LO) begin
				st_d.rdata = st_q.pkt_cnt[15:0];
				st_d.pkt_hi_snap = st_q.pkt_cnt[31:16];
				st_d.err_pkt_snap = st_q.err_pkt;
			end else if (mgmt_req.addr == `LBT_REG_PKT_HI) begin
				st_d.rdata = st_q.pkt_hi_snap;
			end else if (mgmt_req.addr == `LBT_REG_PKT_ERR) begin
				st_d.rdata = st_q.err_pkt_snap;
			end else begin
				st_d.rdata = 16'h0000;
			end
		end

		// MAC receive: generator data goes toward the MAC outside near and reverse loops
		if (gen_on && !lb_near && !lb_rev) begin
			st_d.mac_rx.valid = fifo_in_ready;
			st_d.mac_rx.data = gen_next[7:0];
		end else begin
			st_d.mac_rx = rx_stream;
		end

		st_d.rx_iso  = lb_dig;
		st_d.pma_iso = lb_pcs;
		st_d.tx_iso  = lb_rev;

		// test clock on the pin only in follower mode
		st_d.clk_pin = (st_q.clk_route == `LBT_CLK_TO_PIN) && follower_mode && st_q.tclk;

		// Test mode symbols
		st_d.scr = {st_q.scr[9:0], scr_bit};
		case (tm_mode)
			`LBT_TM_DROOP: begin
				// hold each level at least 600 ns
				if (st_q.tm_cnt == 7'(`LBT_DROOP_CYC - 1)) begin
					st_d.tm_cnt = '0;
					st_d.tm_pol = ~st_q.tm_pol;
				end else begin
					st_d.tm_cnt = st_q.tm_cnt + 1'b1;
				end
				st_d.sym = st_q.tm_pol ? `LBT_SYM_MINUS : `LBT_SYM_PLUS;
			end
			`LBT_TM_JITTER: begin
				st_d.tm_pol = ~st_q.tm_pol;
				st_d.sym = st_q.tm_pol ? `LBT_SYM_MINUS : `LBT_SYM_PLUS;
			end
			`LBT_TM_DIST: begin
				case (tm4_pair)
					2'h1:    st_d.sym = `LBT_SYM_PLUS;
					2'h3:    st_d.sym = `LBT_SYM_MINUS;
					default: st_d.sym = `LBT_SYM_ZERO;
				endcase
			end
			`LBT_TM_PSD: begin
				case ({st_q.scr[3], st_q.scr[0]})
					2'h1:    st_d.sym = `LBT_SYM_PLUS;
					2'h2:    st_d.sym = `LBT_SYM_MINUS;
					default: st_d.sym = `LBT_SYM_ZERO;
				endcase
			end
			default: begin
				st_d.sym = `LBT_SYM_ZERO;
				st_d.tm_cnt = '0;
				st_d.tm_pol = 1'b0;
			end
		endcase
	end

	// ==================================================
	// Registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= '0;
			st_q.chk_st <= LBT_CHK_HUNT;
			st_q.gen_lfsr <= `LBT_PRBS_SEED;
			st_q.scr <= `LBT_SCR_SEED;
		end else begin
			st_q <= st_d;
		end
	end

	assign mgmt_rdata        = st_q.rdata;
	assign mgmt_rvalid       = st_q.rvalid;
	assign mac_rx            = st_q.mac_rx;
	assign tm_symbol         = st_q.sym;
	assign rx_analog_isolate = st_q.rx_iso;
	assign rx_pma_isolate    = st_q.pma_iso;
	assign mac_tx_isolate    = st_q.tx_iso;
	assign clock_output_pin  = st_q.clk_pin;

	// ==================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence seq_update_write;
		mgmt_req.wr && mgmt_req.addr == `LBT_REG_CHK_STAT && mgmt_req.wdata[`LBT_STAT_UPD_BIT];
	endsequence

	sequence seq_status_read;
		mgmt_req.rd && !mgmt_req.wr && mgmt_req.addr == `LBT_REG_CHK_STAT;
	endsequence

	a_update_snap: assert property (seq_update_write ##1 seq_status_read |=>
		mgmt_rvalid && mgmt_rdata[7:0] == $past(st_q.err_cnt, 2))
		else $error("Status read does not return the updated count");
	a_lock_bit: assert property (seq_status_read |=>
		mgmt_rdata[`LBT_STAT_LOCK_BIT] == ($past(st_q.chk_st) == LBT_CHK_LOCK))
		else $error("Lock bit does not match checker state");
	a_near_noline: assert property ((lb_dig || lb_pcs) |-> !line_tx_valid && fifo_out_ready)
		else $error("Line transmit active during near loopback");
	a_dig_isolate: assert property (lb_dig ##1 lb_dig |-> rx_analog_isolate && !mac_tx_isolate)
		else $error("Receive analog not isolated in digital loopback");
	a_rev_mactx: assert property (lb_rev |-> !mac_tx_ready)
		else $error("MAC transmit accepted during reverse loopback");
	a_one_iso: assert property ($onehot0({rx_analog_isolate, rx_pma_isolate, mac_tx_isolate}))
		else $error("More than one loopback isolation active");
	a_tm1_period: assert property (tm_mode == `LBT_TM_DROOP && $past(tm_mode) == `LBT_TM_DROOP &&
		$changed(st_q.tm_pol) |-> $past(st_q.tm_cnt) == 7'(`LBT_DROOP_CYC - 1))
		else $error("Droop level held for the wrong time");
	a_tm2_alt: assert property (tm_mode == `LBT_TM_JITTER ##1 tm_mode == `LBT_TM_JITTER |=>
		tm_symbol != $past(tm_symbol) && tm_symbol != `LBT_SYM_ZERO)
		else $error("Jitter mode symbols do not alternate");
	a_tm4_map: assert property (tm_mode == `LBT_TM_DIST && tm4_pair == 2'h3 |=> tm_symbol == `LBT_SYM_MINUS)
		else $error("Distortion mode pair 11 not mapped to minus one");
	a_normal_tm: assert property (!tm_active |=> tm_symbol == `LBT_SYM_ZERO)
		else $error("Test symbol sent in normal operation");

endmodule // lbt_top

//--- common/lbt_map.svh
// Register offsets, codes and timing counts of the loopback and test-mode block
`ifndef LBT_MAP_SVH
`define LBT_MAP_SVH

// ==================================================
// Register offsets on the management port
`define LBT_REG_LB_SEL     16'h0016
`define LBT_REG_CLK_ROUTE  16'h045F
`define LBT_REG_CHK_CTRL   16'h0619
`define LBT_REG_CHK_STAT   16'h0620
`define LBT_REG_GEN_CFG    16'h0624
`define LBT_REG_PKT_LO     16'h063C
`define LBT_REG_PKT_HI     16'h063D
`define LBT_REG_PKT_ERR    16'h063E
`define LBT_REG_TM_CTRL    16'h1836

// ==================================================
// Loopback select codes
`define LBT_LB_PCS         16'h0102
`define LBT_LB_DIG         16'h0104
`define LBT_LB_ANA         16'h0108
`define LBT_LB_REV         16'h0110

// ==================================================
// Generator, checker and clock routing codes
`define LBT_GEN_RUN        16'h55BF
`define LBT_CHK_MAC_LOOP   16'h1555
`define LBT_CHK_CABLE      16'h0557
`define LBT_CHK_REV_RGMII  16'h1004
`define LBT_CHK_REV_SGMII  16'h1114
`define LBT_CHK_REV_RMII   16'h1224
`define LBT_CHK_REV_MII    16'h1334
`define LBT_CLK_TO_PIN     16'h000D

// ==================================================
// Field positions, reset values and lock thresholds
`define LBT_STAT_UPD_BIT   1
`define LBT_STAT_LOCK_BIT  8
`define LBT_TM_HI          15
`define LBT_TM_LO          13
`define LBT_PRBS_SEED      15'h7FFF
`define LBT_SCR_SEED       11'h7FF
`define LBT_LOCK_GOOD      2'h3
`define LBT_LOCK_BAD       2'h3

// ==================================================
// Test mode codes and ternary symbol codes
`define LBT_TM_DROOP       3'h1
`define LBT_TM_JITTER      3'h2
`define LBT_TM_DIST        3'h4
`define LBT_TM_PSD         3'h5
`define LBT_SYM_ZERO       2'h0
`define LBT_SYM_PLUS       2'h1
`define LBT_SYM_MINUS      2'h3

// ==================================================
// Timing: least hold time of each droop half period
`define LBT_CLK_NS         10
`define LBT_DROOP_NS       600
`define LBT_DROOP_CYC      ((`LBT_DROOP_NS + `LBT_CLK_NS - 1) / `LBT_CLK_NS)

`endif

//--- common/lbt_pkg.sv
// Types shared by the loopback and test-mode block
package lbt_pkg;

	// ==================================================
	// Carriers
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} lbt_mgmt_req_t;

	typedef struct packed {
		logic       en;
		logic       er;
		logic [7:0] data;
	} lbt_mii_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} lbt_byte_t;

	// ==================================================
	// Modes and states
	typedef enum logic [1:0] {
		LBT_IF_RGMII = 2'h0,
		LBT_IF_SGMII = 2'h1,
		LBT_IF_RMII  = 2'h2,
		LBT_IF_MII   = 2'h3
	} lbt_macif_t;

	typedef enum logic [1:0] {
		LBT_CHK_HUNT = 2'b01,
		LBT_CHK_LOCK = 2'b10
	} lbt_chk_st_t;

endpackage

//--- rtl/lbt_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module lbt_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} lbt_fifo_st_t;

	lbt_fifo_st_t st_q;
	lbt_fifo_st_t st_d;
	logic         push;
	logic         pop;

	// ==================================================
	// Flags: full when pointers differ only in the wrap bit
	assign in_ready  = !((st_q.wp[AW] != st_q.rp[AW]) && (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]));
	assign out_valid = (st_q.wp != st_q.rp);
	assign out_data  = st_q.mem[st_q.rp[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Next state
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wp[AW-1:0]] = in_data;
			st_d.wp = st_q.wp + 1'b1;
		end
		if (pop) begin
			st_d.rp = st_q.rp + 1'b1;
		end
	end

	// Storage is not cleared; only the pointers need a reset value
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q.wp <= '0;
			st_q.rp <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule // lbt_fifo

//--- tb/lbt_line_partner.sv
// Line-side link partner model: transmit sink with stall, receive byte source
`timescale 1ns/1ps
module lbt_line_partner (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              stall,
	input  wire logic              line_tx_valid,
	input  wire logic [7:0]        line_tx_data,
	output logic                   line_tx_ready,
	output lbt_pkg::lbt_byte_t     line_rx
);
	logic [7:0] got[$];
	initial begin
		line_rx = '0;
		line_tx_ready = 1'b0;
	end
	// ==================================================
	// Sink: bytes taken only on valid and ready at the same edge
	always @(posedge clk) begin
		line_tx_ready <= nrst && !stall;
		if (line_tx_valid && line_tx_ready) got.push_back(line_tx_data);
	end
	// Source: idle data shows the inverse of the last byte, never stale
	task send(input logic [7:0] b);
		@(posedge clk);
		line_rx <= '{valid: 1'b1, data: b};
		@(posedge clk);
		line_rx <= '{valid: 1'b0, data: ~b};
	endtask
endmodule // lbt_line_partner

//--- tb/tb_loopback_prbs_test_modes.sv
// Self-checking bench of loopback paths, PRBS checker and transmit test modes
`timescale 1ns/1ps
`include "lbt_map.svh"
module tb_loopback_prbs_test_modes;
	import lbt_pkg::*;
	logic clk = 0, nrst = 0, fol = 0, stall = 0, ltv, ltr, ckp, tma, iso_a, iso_p, iso_m, rv, mrdy;
	lbt_mgmt_req_t req = '0;
	lbt_mii_t mtx = '0;
	lbt_byte_t mrx, lrx;
	lbt_macif_t mif = LBT_IF_SGMII;
	logic [15:0] rd_v;
	logic [7:0] ltd, b;
	logic [1:0] sym, s;
	int errors = 0, n_checks = 0, i, n;
	logic [15:0] lb_code[5] = '{16'h0102, 16'h0104, 16'h0108, 16'h0110, 16'h0100};
	logic [3:0] lb_exp[5] = '{4'b0101, 4'b1001, 4'b0001, 4'b0010, 4'b0001};
	logic [7:0] tm_act = 8'b0011_0110;
	lbt_top DUT (.clk(clk), .nrst(nrst), .mgmt_req(req), .mgmt_rdata(rd_v), .mgmt_rvalid(rv),
		.mac_if(mif), .follower_mode(fol), .mac_tx(mtx), .mac_tx_ready(mrdy), .mac_rx(mrx),
		.line_rx(lrx), .line_tx_valid(ltv), .line_tx_data(ltd), .line_tx_ready(ltr),
		.tm_symbol(sym), .tm_active(tma), .rx_analog_isolate(iso_a), .rx_pma_isolate(iso_p),
		.mac_tx_isolate(iso_m), .clock_output_pin(ckp));
	lbt_line_partner p (.clk(clk), .nrst(nrst), .stall(stall), .line_tx_valid(ltv),
		.line_tx_data(ltd), .line_tx_ready(ltr), .line_rx(lrx));
	initial begin
		forever #5 clk = ~clk;
	end
	// ==================================================
	// Shared tasks
	task tally_and_finish;
		if (errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk) req <= '0;
	endtask
	// Read answer stands one cycle, so it is sampled just after the taking edge
	task rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk) req <= '0;
		#1 chk({15'h0000, rv}, 16'h0001);
		chk(rd_v, e);
	endtask
	task mac(input logic [7:0] d);
		@(posedge clk) mtx <= '{en: 1'b1, er: 1'b0, data: d};
		@(posedge clk) mtx <= '0;
	endtask
	// Receive pulse stands one cycle from the edge that launches it, so look just after that edge
	task wait_rx(input logic [7:0] e);
		#1;
		for (i = 0; i < 10 && mrx.valid !== 1'b1; i++) @(posedge clk) #1;
		chk({15'h0000, mrx.valid}, 16'h0001);
		chk({8'h00, mrx.data}, {8'h00, e});
	endtask
	// Update then status read on back-to-back cycles
	task upd_rd(input logic [15:0] e);
		@(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: `LBT_REG_CHK_STAT, wdata: 16'h0002};
		@(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: `LBT_REG_CHK_STAT, wdata: 16'h0000};
		@(posedge clk) req <= '0;
		#1 chk({15'h0000, rv}, 16'h0001);
		chk(rd_v, e);
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		tally_and_finish;
	end
	// ==================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1 chk({rv, sym, tma, iso_a, iso_p, iso_m, ckp, mrdy}, 16'h0001);
		// Loopback codes against isolation levels and MAC transmit acceptance
		for (int r = 0; r < 5; r++) begin
			wr(`LBT_REG_LB_SEL, lb_code[r]);
			repeat (3) @(posedge clk);
			#1 chk({iso_a, iso_p, iso_m, mrdy}, lb_exp[r]);
		end
		// Transmit test mode field, every code
		for (int m = 0; m < 8; m++) begin
			wr(`LBT_REG_TM_CTRL, {m[2:0], 13'h0000});
			repeat (2) @(posedge clk);
			#1 chk({15'h0000, tma}, {15'h0000, tm_act[m]});
			if (!tm_act[m]) chk({14'h0000, sym}, 16'h0000);
		end
		wr(`LBT_REG_TM_CTRL, 16'h4000);
		repeat (2) @(posedge clk);
		#1 s = sym;
		@(posedge clk) #1 chk({s, sym}, (s == 2'h1) ? 16'h0007 : 16'h000D);
		// Droop mode: measure one full half period
		wr(`LBT_REG_TM_CTRL, 16'h2000);
		@(posedge clk) #1 s = sym;
		for (i = 0; i < 200 && sym === s; i++) @(posedge clk) #1;
		s = sym;
		for (n = 0; n < 200 && sym === s; n++) @(posedge clk) #1;
		chk(n[15:0], 16'h003C);
		wr(`LBT_REG_TM_CTRL, 16'h0000);
		// Digital loopback of a MAC frame, then grouped packet counters
		wr(`LBT_REG_LB_SEL, `LBT_LB_DIG);
		wr(`LBT_REG_CHK_CTRL, `LBT_CHK_MAC_LOOP);
		mac(8'hA5);
		wait_rx(8'hA5);
		rd(`LBT_REG_PKT_LO, 16'h0001);
		rd(`LBT_REG_PKT_HI, 16'h0000);
		rd(`LBT_REG_PKT_ERR, 16'h0000);
		chk(p.got.size(), 16'h0000);
		// Cable-side PRBS through the near loop: lock with no errors
		wr(`LBT_REG_GEN_CFG, `LBT_GEN_RUN);
		wr(`LBT_REG_CHK_CTRL, `LBT_CHK_CABLE);
		repeat (60) @(posedge clk);
		#1 chk({15'h0000, mrdy}, 16'h0000);
		wr(`LBT_REG_CHK_STAT, 16'h0002);
		rd(`LBT_REG_CHK_STAT, 16'h0100);
		wr(`LBT_REG_GEN_CFG, 16'h0000);
		upd_rd(16'h0100);
		// Analog loopback receive, then transmit FIFO filled against a stalled line
		wr(`LBT_REG_LB_SEL, `LBT_LB_ANA);
		p.send(8'h3C);
		wait_rx(8'h3C);
		@(posedge clk) stall <= 1'b1;
		for (int k = 0; k < 8; k++) mac(k[7:0]);
		#1 chk({15'h0000, mrdy}, 16'h0000);
		@(posedge clk) stall <= 1'b0;
		repeat (15) @(posedge clk);
		chk(p.got.size(), 16'h0008);
		chk({8'h00, p.got[7]}, 16'h0007);
		// Reverse loopback returns line data to the line
		wr(`LBT_REG_LB_SEL, `LBT_LB_REV);
		p.send(8'hC3);
		repeat (6) @(posedge clk);
		chk({8'h00, p.got[p.got.size() - 1]}, 16'h00C3);
		// Reverse loopback MAC checker code for the active interface; MAC byte stays off the line
		wr(`LBT_REG_CHK_CTRL, `LBT_CHK_REV_SGMII);
		mac(8'h11);
		rd(`LBT_REG_PKT_LO, 16'h0002);
		chk(p.got.size(), 16'h0009);
		// Clock routing in follower mode, and an unmapped read
		@(posedge clk) fol <= 1'b1;
		wr(`LBT_REG_CLK_ROUTE, `LBT_CLK_TO_PIN);
		repeat (3) @(posedge clk);
		#1 b = {7'h00, ckp};
		@(posedge clk) #1 chk({15'h0000, ckp}, {15'h0000, ~b[0]});
		rd(16'h0700, 16'h0000);
		// Mid-run reset clears registers, outputs and the FIFO
		@(posedge clk) nrst <= 1'b0;
		@(posedge clk) nrst <= 1'b1;
		#1 chk({rv, sym, tma, iso_a, iso_p, iso_m, ckp, mrdy}, 16'h0001);
		rd(`LBT_REG_LB_SEL, 16'h0000);
		tally_and_finish;
	end
endmodule // tb_loopback_prbs_test_modes
